// ---- logic/pif_pkg.sv ----
`default_nettype none
// shared constants for the peripheral flag registers and their link
package pif_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFS_REQ_2 = 8'h8E;
    localparam logic [7:0] OFS_REQ_3 = 8'h8F;
    localparam logic [7:0] OFS_REQ_4 = 8'h90;

    // value after reset of every flag register
    localparam logic [7:0] REQ_RESET = 8'h00;

    // second register field positions
    localparam int POS_CAPCMP_B   = 6;
    localparam int POS_CAPCMP_A   = 5;
    localparam int POS_TIMER_FOUR = 4 - 1;
    localparam int POS_TIMER_TWO  = 2;
    localparam int POS_TIMER_GATE = 1;
    localparam int POS_TIMER_THREE = 0;

    // third register field positions
    localparam int POS_PWM_B_PARAM  = 3;
    localparam int POS_PWM_B_PERIOD = 2;
    localparam int POS_PWM_A_PARAM  = 1;
    localparam int POS_PWM_A_PERIOD = 0;

    // fourth register field positions
    localparam int POS_SERIAL_RX   = 7;
    localparam int POS_SERIAL_TX   = 6;
    localparam int POS_LOGIC_CELL  = 2;
    localparam int POS_WAVE_GEN    = 1;
    localparam int POS_NUM_OSC     = 0;

    // implemented and software-writable bits per register
    localparam logic [7:0] MASK_REQ_2    = 8'h6F;
    localparam logic [7:0] MASK_REQ_3    = 8'h0F;
    localparam logic [7:0] MASK_REQ_4_WR = 8'h3F;

    // number of configurable logic cells and units per pair
    localparam int LOGIC_CELLS = 4;
    localparam int UNIT_PAIR   = 2;

endpackage : pif_pkg
`default_nettype wire

// ---- logic/pif_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// link between the event/software side and the flag registers
interface pif_link_if;

    // software register access
    logic [pif_pkg::ADDR_W-1:0]      bus_addr;
    logic [pif_pkg::DATA_W-1:0]      bus_wdata;
    logic                            bus_wr;
    logic                            bus_rd;
    logic [pif_pkg::DATA_W-1:0]      bus_rdata;

    // peripheral events, one-cycle pulses except the gate active level; index 1 is unit b
    logic [pif_pkg::UNIT_PAIR-1:0]   capcmp_evt;
    logic                            timer_four_evt;
    logic                            timer_two_evt;
    logic                            timer_three_evt;
    logic                            timer_three_gate_act;
    logic [pif_pkg::UNIT_PAIR-1:0]   pwm_param_evt;
    logic [pif_pkg::UNIT_PAIR-1:0]   pwm_period_evt;
    logic [pif_pkg::LOGIC_CELLS-1:0] logic_cell_evt;
    logic                            waveform_gen_evt;
    logic                            num_osc_evt;

    // serial buffer state levels
    logic                            rx_not_empty;
    logic                            tx_empty;

    modport flags (
        input  bus_addr, bus_wdata, bus_wr, bus_rd,
        output bus_rdata,
        input  capcmp_evt, timer_four_evt, timer_two_evt, timer_three_evt,
        input  timer_three_gate_act, pwm_param_evt, pwm_period_evt,
        input  logic_cell_evt, waveform_gen_evt, num_osc_evt,
        input  rx_not_empty, tx_empty
    );

    modport source (
        output bus_addr, bus_wdata, bus_wr, bus_rd,
        input  bus_rdata,
        output capcmp_evt, timer_four_evt, timer_two_evt, timer_three_evt,
        output timer_three_gate_act, pwm_param_evt, pwm_period_evt,
        output logic_cell_evt, waveform_gen_evt, num_osc_evt,
        output rx_not_empty, tx_empty
    );

endinterface : pif_link_if
`default_nettype wire

// ---- logic/pif_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// far end: registers software strobes and peripheral events onto the link
module pif_source (
    input  wire logic                            mclk,
    input  wire logic                            nrst,
    // software port
    input  wire logic [pif_pkg::ADDR_W-1:0]      sw_addr,
    input  wire logic [pif_pkg::DATA_W-1:0]      sw_wdata,
    input  wire logic                            sw_wr,
    input  wire logic                            sw_rd,
    output logic      [pif_pkg::DATA_W-1:0]      sw_rdata,
    // peripheral events and buffer levels
    input  wire logic [pif_pkg::UNIT_PAIR-1:0]   capcmp_evt,
    input  wire logic                            timer_four_evt,
    input  wire logic                            timer_two_evt,
    input  wire logic                            timer_three_evt,
    input  wire logic                            timer_three_gate_act,
    input  wire logic [pif_pkg::UNIT_PAIR-1:0]   pwm_param_evt,
    input  wire logic [pif_pkg::UNIT_PAIR-1:0]   pwm_period_evt,
    input  wire logic [pif_pkg::LOGIC_CELLS-1:0] logic_cell_evt,
    input  wire logic                            waveform_gen_evt,
    input  wire logic                            num_osc_evt,
    input  wire logic                            rx_not_empty,
    input  wire logic                            tx_empty,
    pif_link_if.source                           link
);

    typedef struct packed {
        logic [pif_pkg::ADDR_W-1:0]      addr;
        logic [pif_pkg::DATA_W-1:0]      wdata;
        logic                            wr;
        logic                            rd;
        logic [pif_pkg::DATA_W-1:0]      rdata;
        logic [pif_pkg::UNIT_PAIR-1:0]   capcmp;
        logic                            tmr4;
        logic                            tmr2;
        logic                            tmr3;
        logic                            gate;
        logic [pif_pkg::UNIT_PAIR-1:0]   pparam;
        logic [pif_pkg::UNIT_PAIR-1:0]   pperiod;
        logic [pif_pkg::LOGIC_CELLS-1:0] cells;
        logic                            wave;
        logic                            osc;
        logic                            rxne;
        logic                            txe;
    } pif_src_s;

    pif_src_s st;
    pif_src_s next_st;

    // capture everything one cycle before it reaches the link
    always_comb begin
        next_st         = st;
        next_st.addr    = sw_addr;
        next_st.wdata   = sw_wdata;
        next_st.wr      = sw_wr;
        next_st.rd      = sw_rd && !sw_wr; // strobes never both at once
        next_st.rdata   = link.bus_rdata;
        next_st.capcmp  = capcmp_evt;
        next_st.tmr4    = timer_four_evt;
        next_st.tmr2    = timer_two_evt;
        next_st.tmr3    = timer_three_evt;
        next_st.gate    = timer_three_gate_act;
        next_st.pparam  = pwm_param_evt;
        next_st.pperiod = pwm_period_evt;
        next_st.cells   = logic_cell_evt;
        next_st.wave    = waveform_gen_evt;
        next_st.osc     = num_osc_evt;
        next_st.rxne    = rx_not_empty;
        next_st.txe     = tx_empty;
    end

    // state register; tx buffer starts empty
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st     <= '0;
            st.txe <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // drive the link and the software read data from the flops
    assign link.bus_addr             = st.addr;
    assign link.bus_wdata            = st.wdata;
    assign link.bus_wr               = st.wr;
    assign link.bus_rd               = st.rd;
    assign link.capcmp_evt           = st.capcmp;
    assign link.timer_four_evt       = st.tmr4;
    assign link.timer_two_evt        = st.tmr2;
    assign link.timer_three_evt      = st.tmr3;
    assign link.timer_three_gate_act = st.gate;
    assign link.pwm_param_evt        = st.pparam;
    assign link.pwm_period_evt       = st.pperiod;
    assign link.logic_cell_evt       = st.cells;
    assign link.waveform_gen_evt     = st.wave;
    assign link.num_osc_evt          = st.osc;
    assign link.rx_not_empty         = st.rxne;
    assign link.tx_empty             = st.txe;
    assign sw_rdata                  = st.rdata;

endmodule : pif_source
`default_nettype wire

// ---- logic/pif_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - capture/compare flags set on unit event, sticky
// - second register bit layout 6,5,3,2,1,0
// - timer flags set on event until written
// - gate flag sets when gate goes inactive
// - parameter flags at bits 3 and 1
// - period flags at bits 2 and 0
// - fourth register at 0x90, reset zero
// - receive flag follows receive buffer non-empty
// - receive flag read-only, writes ignored
// - transmit flag high while buffer empty, read-only
// - software polls shift-empty status for completion
// - logic cell flags sticky until written
// - waveform generator flag at bit 1
// - oscillator flag at bit 0
// - flags set regardless of any enable
// - software clears flags before enabling
// - second register at 0x8E, reset zero
module pif_flags (
    input  wire logic        mclk,
    input  wire logic        nrst,
    pif_link_if.flags        link,
    output logic      [7:0]  req_2_flags,
    output logic      [7:0]  req_3_flags,
    output logic      [7:0]  req_4_flags
);

    // field views of the flag registers, bit 7 first
    typedef struct packed {
        logic rsvd_7;
        logic capcmp_unit_b_flag;
        logic capcmp_unit_a_flag;
        logic rsvd_4;
        logic timer_four_flag;
        logic timer_two_flag;
        logic timer_three_gate_flag;
        logic timer_three_flag;
    } pif_req_2_s;

    typedef struct packed {
        logic [3:0] rsvd;
        logic       pwm_b_param_flag;
        logic       pwm_b_period_flag;
        logic       pwm_a_param_flag;
        logic       pwm_a_period_flag;
    } pif_req_3_s;

    typedef struct packed {
        logic       serial_rx_flag;
        logic       serial_tx_flag;
        logic       logic_cell_d_flag;
        logic       logic_cell_c_flag;
        logic       logic_cell_b_flag;
        logic       logic_cell_a_flag;
        logic       waveform_gen_flag;
        logic       num_osc_flag;
    } pif_req_4_s;

    typedef struct packed {
        pif_req_2_s req_2;
        pif_req_3_s req_3;
        pif_req_4_s req_4;
        logic       gate_prev;
        logic [7:0] rdata;
    } pif_flags_s;

    pif_flags_s st;
    pif_flags_s next_st;

    // register hits and per-register set pulses
    logic       hit_2;
    logic       hit_3;
    logic       hit_4;
    logic [7:0] set_2;
    logic [7:0] set_3;
    logic [7:0] set_4;
    logic       gate_fell;

    // address decode of the write and read strobes
    always_comb begin
        hit_2 = 1'b0;
        hit_3 = 1'b0;
        hit_4 = 1'b0;
        if (link.bus_addr == pif_pkg::OFS_REQ_2) begin
            hit_2 = 1'b1;
        end else if (link.bus_addr == pif_pkg::OFS_REQ_3) begin
            hit_3 = 1'b1;
        end else if (link.bus_addr == pif_pkg::OFS_REQ_4) begin
            hit_4 = 1'b1;
        end
    end

    // gate active-to-inactive edge, same clock so no synchroniser
    // gate_prev resets low, so a gate held active through reset
    // cannot fake an edge; a gate idle inactive raises nothing
    assign gate_fell = st.gate_prev && !link.timer_three_gate_act;

    // second register set sources
    always_comb begin
        set_2 = 8'h00;
        set_2[pif_pkg::POS_CAPCMP_B]    = link.capcmp_evt[1];
        set_2[pif_pkg::POS_CAPCMP_A]    = link.capcmp_evt[0];
        set_2[pif_pkg::POS_TIMER_FOUR]  = link.timer_four_evt;
        set_2[pif_pkg::POS_TIMER_TWO]   = link.timer_two_evt;
        set_2[pif_pkg::POS_TIMER_GATE]  = gate_fell;
        set_2[pif_pkg::POS_TIMER_THREE] = link.timer_three_evt;
    end

    // third register set sources
    always_comb begin
        set_3 = 8'h00;
        set_3[pif_pkg::POS_PWM_B_PARAM]  = link.pwm_param_evt[1];
        set_3[pif_pkg::POS_PWM_A_PARAM]  = link.pwm_param_evt[0];
        set_3[pif_pkg::POS_PWM_B_PERIOD] = link.pwm_period_evt[1];
        set_3[pif_pkg::POS_PWM_A_PERIOD] = link.pwm_period_evt[0];
    end

    // fourth register set sources for the sticky bits
    always_comb begin
        set_4 = 8'h00;
        set_4[pif_pkg::POS_LOGIC_CELL +: pif_pkg::LOGIC_CELLS] =
            link.logic_cell_evt;
        set_4[pif_pkg::POS_WAVE_GEN] = link.waveform_gen_evt;
        set_4[pif_pkg::POS_NUM_OSC]  = link.num_osc_evt;
    end

    // software write enables, one per decoded register
    logic       wr_2;
    logic       wr_3;
    logic       wr_4;

    // a write counts only on a decoded address; others are dropped
    assign wr_2 = link.bus_wr && hit_2;
    assign wr_3 = link.bus_wr && hit_3;
    assign wr_4 = link.bus_wr && hit_4;

    // register contents after the software write alone
    // reserved bits are masked off so they never read back as one
    // the serial bits are dropped here and rebuilt from the levels
    logic [7:0] kept_2;
    logic [7:0] kept_3;
    logic [7:0] kept_4;

    always_comb begin
        kept_2 = st.req_2;
        kept_3 = st.req_3;
        kept_4 = st.req_4 & pif_pkg::MASK_REQ_4_WR;
        if (wr_2) begin
            kept_2 = link.bus_wdata & pif_pkg::MASK_REQ_2;
        end
        if (wr_3) begin
            kept_3 = link.bus_wdata & pif_pkg::MASK_REQ_3;
        end
        if (wr_4) begin
            kept_4 = link.bus_wdata & pif_pkg::MASK_REQ_4_WR;
        end
    end

    // serial flags mirror the buffer levels one cycle late
    // software clears them only through the serial peripheral
    logic [7:0] level_4;

    always_comb begin
        level_4 = 8'h00;
        level_4[pif_pkg::POS_SERIAL_RX] = link.rx_not_empty;
        level_4[pif_pkg::POS_SERIAL_TX] = link.tx_empty;
    end

    // read data source; unmapped addresses read as zero
    // the value is taken before this cycle's update, so a set
    // landing beside the read shows up on the next read
    logic [7:0] rd_sel;

    always_comb begin
        rd_sel = 8'h00;
        if (hit_2) begin
            rd_sel = st.req_2;
        end else if (hit_3) begin
            rd_sel = st.req_3;
        end else if (hit_4) begin
            rd_sel = st.req_4;
        end
    end

    // next state: write first, then hardware sets on top
    // no enable is consulted, so events land even while masked
    always_comb begin
        next_st           = st;
        next_st.gate_prev = link.timer_three_gate_act;
        next_st.req_2     = kept_2 | set_2;
        next_st.req_3     = kept_3 | set_3;
        next_st.req_4     = kept_4 | set_4 | level_4;
        // read data stand one cycle only, zero otherwise
        next_st.rdata     = link.bus_rd ? rd_sel : 8'h00;
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st       <= '0;
            st.req_2 <= pif_pkg::REQ_RESET;
            st.req_3 <= pif_pkg::REQ_RESET;
            st.req_4 <= pif_pkg::REQ_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign link.bus_rdata  = st.rdata;
    assign req_2_flags     = st.req_2;
    assign req_3_flags     = st.req_3;
    assign req_4_flags     = st.req_4;

endmodule : pif_flags
`default_nettype wire

// ---- verification/pif_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// watches the link between the source end and the flag registers
module pif_assertions (
    input wire logic                            mclk,
    input wire logic                            nrst,
    input wire logic [pif_pkg::ADDR_W-1:0]      bus_addr,
    input wire logic [pif_pkg::DATA_W-1:0]      bus_wdata,
    input wire logic                            bus_wr,
    input wire logic                            bus_rd,
    input wire logic [pif_pkg::DATA_W-1:0]      bus_rdata,
    input wire logic [pif_pkg::UNIT_PAIR-1:0]   capcmp_evt,
    input wire logic                            timer_two_evt,
    input wire logic                            timer_three_gate_act,
    input wire logic [pif_pkg::LOGIC_CELLS-1:0] logic_cell_evt,
    input wire logic                            num_osc_evt,
    input wire logic                            rx_not_empty,
    input wire logic                            tx_empty
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // decoded reads of each register
    wire rd_2 = bus_rd && bus_addr == 8'h8E;
    wire rd_3 = bus_rd && bus_addr == 8'h8F;
    wire rd_4 = bus_rd && bus_addr == 8'h90;
    wire rd_x = bus_rd && !rd_2 && !rd_3 && !rd_4;

    AST_UNMAPPED: assert property (rd_x |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RSVD_2: assert property (rd_2 |=> bus_rdata[7] == 1'b0
        && bus_rdata[4] == 1'b0) else $error("reserved bit set");
    AST_RSVD_3: assert property (rd_3 |=> bus_rdata[7:4] == 4'h0)
        else $error("reserved nibble set");
    AST_RX: assert property (rd_4
        |=> bus_rdata[7] == $past(rx_not_empty, 2))
        else $error("receive flag off buffer level");
    AST_TX: assert property (rd_4
        |=> bus_rdata[6] == $past(tx_empty, 2))
        else $error("transmit flag off buffer level");
    AST_OSC: assert property (num_osc_evt ##1 rd_4 |=> bus_rdata[0])
        else $error("oscillator flag not set");
    AST_TIMER: assert property (timer_two_evt ##1 rd_2 |=> bus_rdata[2])
        else $error("timer flag not set");
    AST_GATE: assert property ($fell(timer_three_gate_act) ##1 rd_2
        |=> bus_rdata[1]) else $error("gate flag not set");
    AST_SET_WINS: assert property (logic_cell_evt[0] && bus_wr
        && bus_addr == 8'h90 && !bus_wdata[2] ##1 rd_4 |=> bus_rdata[2])
        else $error("clear beat set");
    AST_CLEAR: assert property (bus_wr && bus_addr == 8'h8E
        && bus_wdata == 8'h00 && capcmp_evt == 2'b00 ##1 rd_2
        |=> bus_rdata[6:5] == 2'b00) else $error("clear failed");
endmodule // pif_assertions
`default_nettype wire

// ---- verification/peripheral_irq_flag_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_regs_tb_top;
    logic        mclk, nrst, sw_wr, sw_rd, gate, rx, tx;
    logic [7:0]  sw_addr, sw_wdata, sw_rdata, f2, f3, f4, base, a;
    logic [15:0] t;
    logic [14:0] ev;
    int          fail_count = 0, check_count = 0, cycles = 0, i;

    // register address and bit mask of each event, indexed as ev
    function automatic logic [15:0] tab(input int n);
        case (n)
            0:  return 16'h8E20;
            1:  return 16'h8E40;
            2:  return 16'h8E08;
            3:  return 16'h8E04;
            4:  return 16'h8E01;
            5:  return 16'h8F02;
            6:  return 16'h8F08;
            7:  return 16'h8F01;
            8:  return 16'h8F04;
            9:  return 16'h9004;
            10: return 16'h9008;
            11: return 16'h9010;
            12: return 16'h9020;
            13: return 16'h9002;
            default: return 16'h9001;
        endcase
    endfunction

    pif_link_if lk ();
    pif_source u_pif_source (.mclk(mclk), .nrst(nrst), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .capcmp_evt(ev[1:0]), .timer_four_evt(ev[2]),
        .timer_two_evt(ev[3]), .timer_three_evt(ev[4]),
        .timer_three_gate_act(gate), .pwm_param_evt(ev[6:5]),
        .pwm_period_evt(ev[8:7]), .logic_cell_evt(ev[12:9]),
        .waveform_gen_evt(ev[13]), .num_osc_evt(ev[14]),
        .rx_not_empty(rx), .tx_empty(tx), .link(lk.source));
    pif_flags u_pif_flags (.mclk(mclk), .nrst(nrst), .link(lk.flags),
        .req_2_flags(f2), .req_3_flags(f3), .req_4_flags(f4));
    pif_assertions u_chk (.mclk(mclk), .nrst(nrst), .bus_addr(lk.bus_addr),
        .bus_wdata(lk.bus_wdata), .bus_wr(lk.bus_wr), .bus_rd(lk.bus_rd),
        .bus_rdata(lk.bus_rdata), .capcmp_evt(lk.capcmp_evt),
        .timer_two_evt(lk.timer_two_evt),
        .timer_three_gate_act(lk.timer_three_gate_act),
        .logic_cell_evt(lk.logic_cell_evt), .num_osc_evt(lk.num_osc_evt),
        .rx_not_empty(lk.rx_not_empty), .tx_empty(lk.tx_empty));

    // clock at 250 MHz
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one write cycle, optionally with event pulses in the same cycle
    task automatic wr(input logic [7:0] ad, input logic [7:0] d,
                      input logic [14:0] e);
        sw_addr <= ad;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        ev <= e;
        @(posedge mclk);
        sw_wr <= 1'b0;
        ev <= '0;
    endtask

    // read data stand in the third cycle after the strobe; they are
    // taken at the edge that ends that cycle, before it updates them
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        sw_addr <= ad;
        sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(sw_rdata, exp);
    endtask

    function automatic logic [7:0] flags_of(input logic [7:0] ad);
        return (ad == 8'h8E) ? f2 : (ad == 8'h8F) ? f3 : f4;
    endfunction

    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        {nrst, sw_wr, sw_rd, gate, rx} = '0;
        {sw_addr, sw_wdata, ev} = '0;
        tx = 1'b1;
        repeat (12) @(posedge mclk);
        chk(f2, 8'h00);
        chk(f3, 8'h00);
        chk(f4, 8'h00);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(8'h90, 8'h40);
        // every event flag but the gate flag: set against a same-cycle clear, then cleared
        for (i = 0; i < 15; i++) begin
            t = tab(i);
            a = t[15:8];
            base = (a == 8'h90) ? 8'h40 : 8'h00;
            wr(a, 8'h00, 15'd1 << i);
            rd(a, base | t[7:0]);
            chk(flags_of(a), base | t[7:0]);
            wr(a, 8'h00, '0);
            rd(a, base);
        end
        // gate going inactive raises its flag
        gate <= 1'b1;
        repeat (3) @(posedge mclk);
        gate <= 1'b0;
        @(posedge mclk);
        rd(8'h8E, 8'h02);
        wr(8'h8E, 8'h00, '0);
        // serial flags follow buffer levels and ignore writes
        rx <= 1'b1;
        tx <= 1'b0;
        wr(8'h90, 8'hFF, '0);
        rd(8'h90, 8'hBF);
        chk(f4, 8'hBF);
        rx <= 1'b0;
        tx <= 1'b1;
        wr(8'h90, 8'hC0, '0);
        rd(8'h90, 8'h40);
        // reserved bits and an unmapped address
        wr(8'h8E, 8'hFF, '0);
        rd(8'h8E, 8'h6F);
        wr(8'h8F, 8'hFF, '0);
        rd(8'h8F, 8'h0F);
        wr(8'h91, 8'hFF, '0);
        rd(8'h91, 8'h00);
        chk(f2, 8'h6F);
        chk(f3, 8'h0F);
        chk(f4, 8'h40);
        report_and_stop();
    end
endmodule // peripheral_irq_flag_regs_tb_top
`default_nettype wire
